// File: dacc_pkg.sv
// Purpose: Constants and types for the dual converter calibration control.
// Assumes: 10 MHz pclk, APB register access, 32-bit data.
// Notes: All offsets, reset values and cycle counts live here.
`default_nettype none
package dacc_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_CONFIG = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   // Control register fields
   localparam int CTRL_CAL_BIT  = 0;
   localparam int CTRL_SKIP_BIT = 1;
   localparam int CTRL_CPA_BIT  = 2;
   // Config register fields
   localparam int CFG_SWING_BIT = 0;
   localparam int CFG_EDGE_BIT  = 1;
   localparam int CFG_FSR_BIT   = 2;
   localparam int CFG_DEMUX_BIT = 3;
   // Reset values
   localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
   localparam logic [31:0] CONFIG_RESET = 32'h0000_0008;
   // Timing
   localparam int CLK_MHZ        = 10;
   localparam int CAL_LOW_CYC    = 80;     // least low cycles before request
   localparam int CAL_HIGH_CYC   = 80;     // least high cycles to request
   localparam int TRIM_CYC       = 1024;   // trim portion length
   localparam int BIAS_CYC       = 4096;   // bias portion length
   localparam int CNT_W          = 16;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_TRIM = 4'b0010,
      ST_BIAS = 4'b0100,
      ST_DONE = 4'b1000
   } cal_state_type;
endpackage
`default_nettype wire

// File: dacc_req_if.sv
// Purpose: Carries calibrate-request detection between modules.
// Assumes: Single pclk domain.
// Notes: Detector drives start, sequencer reads it.
`timescale 1ns/1ps
`default_nettype none
interface dacc_req_if;
   logic level;  // Combined calibrate level
   logic start;  // One-cycle request pulse
   modport det (input level, output start);
   modport seq (output level, input start);
endinterface
`default_nettype wire

// File: dacc_req_det.sv
// Purpose: Detects a held low then held high calibrate level.
// Assumes: Input synchronous to pclk.
// Notes: Pulse fires once the high time is met.
`timescale 1ns/1ps
`default_nettype none
module dacc_req_det #(
   parameter int LOW_CYC  = dacc_pkg::CAL_LOW_CYC,
   parameter int HIGH_CYC = dacc_pkg::CAL_HIGH_CYC
) (
   input  wire logic pclk,
   input  wire logic presetn,
   dacc_req_if.det   req
);
   logic [dacc_pkg::CNT_W-1:0] cnt_ff;
   logic                       armed_ff;
   logic                       fired_ff;
   logic                       start_ff;
   wire low_met  = (cnt_ff >= dacc_pkg::CNT_W'(LOW_CYC - 1));
   wire high_met = (cnt_ff >= dacc_pkg::CNT_W'(HIGH_CYC - 1));
   wire prev_lvl;
   logic lvl_ff;
   assign prev_lvl = lvl_ff;
   // Level unchanged since last edge; counts from a prior level never qualify
   wire steady = (req.level == prev_lvl);
   assign req.start = start_ff;
   // Counts cycles at a steady level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff   <= '0;
         lvl_ff   <= 1'b1;
         armed_ff <= 1'b0;
         fired_ff <= 1'b0;
         start_ff <= 1'b0;
      end else begin
         lvl_ff   <= req.level;
         start_ff <= 1'b0;
         if (!steady) begin
            cnt_ff <= '0;
            if (req.level) begin
               fired_ff <= 1'b0;
            end else begin
               armed_ff <= 1'b0;                 // Fresh low period counted anew
            end
         end else if (!high_met || !low_met) begin
            cnt_ff <= cnt_ff + 1'b1;
         end
         if (steady && !req.level && low_met) begin
            armed_ff <= 1'b1;
         end
         if (steady && req.level && armed_ff && high_met && !fired_ff) begin
            start_ff <= 1'b1;
            fired_ff <= 1'b1;
            armed_ff <= 1'b0;
         end
      end
   end
endmodule // dacc_req_det
`default_nettype wire

// File: dacc_top.sv
// Purpose: Calibration sequencer, range handling and output control.
// Assumes: APB slave, converter words arrive on pclk.
// Notes: Trim and bias counts are parameters for short simulations.
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dacc_top #(
   parameter int DW       = 8,
   parameter int TRIM_CYC = dacc_pkg::TRIM_CYC,
   parameter int BIAS_CYC = dacc_pkg::BIAS_CYC
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic          extended_control_enable,
   input  wire logic          power_down_request,
   input  wire logic          cal_pin,
   input  wire logic          output_swing_pin,
   input  wire logic          output_edge_pin,
   input  wire logic          full_scale_pin,
   input  wire logic          demux_pin,
   input  wire logic [DW-1:0] i_sample,
   input  wire logic [DW-1:0] q_sample,
   input  wire logic          i_under,
   input  wire logic          i_over,
   input  wire logic          q_under,
   input  wire logic          q_over,
   output logic      [DW-1:0] i_primary_bus,
   output logic      [DW-1:0] i_delayed_bus,
   output logic      [DW-1:0] q_primary_bus,
   output logic      [DW-1:0] q_delayed_bus,
   output logic               out_of_range,
   output logic               output_data_clock,
   output logic               output_swing_select,
   output logic               output_edge_select,
   output logic               full_scale_select,
   output logic               calibration_active,
   output logic               trim_active
);
   logic [31:0] ctrl_ff;
   logic [31:0] config_ff;
   logic [31:0] prdata_ff;
   logic        pslverr_ff;
   logic        pready_ff;
   dacc_pkg::cal_state_type state_ff, nxt_state;
   logic [dacc_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
   logic        phase_ff;
   logic [DW-1:0] ip_ff, id_ff, qp_ff, qd_ff, ihold_ff, qhold_ff;
   logic        or_ff, output_data_clock_ff, swing_ff, edge_ff, fsr_ff, act_ff, trim_ff;

   // APB decode
   wire wr_en    = psel && penable && pwrite;
   wire hit_ctrl = (paddr == dacc_pkg::ADDR_CTRL);
   wire hit_cfg  = (paddr == dacc_pkg::ADDR_CONFIG);
   wire hit_stat = (paddr == dacc_pkg::ADDR_STATUS);
   wire unmapped = !(hit_ctrl || hit_cfg || hit_stat);
   wire [31:0] status_word = {28'h0, state_ff};
   wire [31:0] rd_mux = hit_ctrl ? ctrl_ff :
                        hit_cfg  ? config_ff :
                        hit_stat ? {status_word[31:5], act_ff, status_word[3:0]} : 32'h0;

   // Effective settings: registers in extended mode
   wire ext      = extended_control_enable;
   wire cal_bit  = ctrl_ff[dacc_pkg::CTRL_CAL_BIT];
   wire skip_bit = ctrl_ff[dacc_pkg::CTRL_SKIP_BIT];
   wire cpa_bit  = ctrl_ff[dacc_pkg::CTRL_CPA_BIT];
   wire eff_swing = ext ? config_ff[dacc_pkg::CFG_SWING_BIT] : output_swing_pin;
   wire eff_edge  = ext ? config_ff[dacc_pkg::CFG_EDGE_BIT] : output_edge_pin;
   wire eff_fsr   = ext ? config_ff[dacc_pkg::CFG_FSR_BIT] : full_scale_pin;
   wire eff_demux = ext ? config_ff[dacc_pkg::CFG_DEMUX_BIT] : demux_pin;

   // Calibrate request: pin or register bit, same qualification
   dacc_req_if req_if ();
   assign req_if.level = ext ? cal_bit : cal_pin;
   dacc_req_det u_det (
      .pclk    (pclk),
      .presetn (presetn),
      .req     (req_if)
   );

   // Request acceptance
   wire cal_allowed = !power_down_request && (!cpa_bit || skip_bit);
   wire go          = req_if.start && cal_allowed;
   wire do_trim     = !(ext && skip_bit);

   // Saturated codes per channel
   wire [DW-1:0] i_code = i_under ? {DW{1'b0}} : i_over ? {DW{1'b1}} : i_sample;
   wire [DW-1:0] q_code = q_under ? {DW{1'b0}} : q_over ? {DW{1'b1}} : q_sample;
   wire          any_or = i_under || i_over || q_under || q_over;

   // Sequencer next state
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      case (state_ff)
         dacc_pkg::ST_IDLE: begin
            nxt_cnt = '0;
            if (go) begin
               nxt_state = do_trim ? dacc_pkg::ST_TRIM : dacc_pkg::ST_BIAS;
            end
         end
         dacc_pkg::ST_TRIM: begin
            if (power_down_request) begin
               nxt_state = dacc_pkg::ST_IDLE;
            end else if (cnt_ff == dacc_pkg::CNT_W'(TRIM_CYC - 1)) begin
               nxt_state = dacc_pkg::ST_BIAS;
               nxt_cnt   = '0;
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end
         dacc_pkg::ST_BIAS: begin
            if (power_down_request) begin
               nxt_state = dacc_pkg::ST_IDLE;
            end else if (cnt_ff == dacc_pkg::CNT_W'(BIAS_CYC - 1)) begin
               nxt_state = dacc_pkg::ST_DONE;
               nxt_cnt   = '0;
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end
         dacc_pkg::ST_DONE: begin
            nxt_state = dacc_pkg::ST_IDLE;
         end
         default: begin
            nxt_state = dacc_pkg::ST_IDLE;
            nxt_cnt   = '0;
         end
      endcase
   end

   wire running  = (nxt_state == dacc_pkg::ST_TRIM) || (nxt_state == dacc_pkg::ST_BIAS);
   wire trimming = (nxt_state == dacc_pkg::ST_TRIM);

   // APB register writes; calibrate bit kept until software clears it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff   <= dacc_pkg::CTRL_RESET;
         config_ff <= dacc_pkg::CONFIG_RESET;
      end else if (wr_en && hit_ctrl) begin
         ctrl_ff   <= {29'h0, pwdata[2:0]};
      end else if (wr_en && hit_cfg) begin
         config_ff <= {28'h0, pwdata[3:0]};
      end
   end

   // APB read data and error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff  <= 32'h0;
         pslverr_ff <= 1'b0;
         pready_ff  <= 1'b0;
      end else begin
         prdata_ff  <= (psel && !penable && !pwrite) ? rd_mux : prdata_ff;
         pslverr_ff <= psel && !penable && unmapped;    // Stands in the access cycle
         pready_ff  <= 1'b1;                            // Zero wait states
      end
   end
   assign prdata  = prdata_ff;
   assign pready  = pready_ff;
   assign pslverr = pslverr_ff;

   // Sequencer state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff    <= dacc_pkg::ST_IDLE;
         cnt_ff      <= '0;
      end else begin
         state_ff    <= nxt_state;   // no automatic run after reset
         cnt_ff      <= nxt_cnt;
      end
   end

   // Demux phase toggles each sample
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_ff <= 1'b0;
      end else if (!trimming) begin
         phase_ff <= eff_demux ? !phase_ff : 1'b0;
      end
   end

   // Output words and flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ip_ff    <= '0;
         id_ff    <= '0;
         qp_ff    <= '0;
         qd_ff    <= '0;
         ihold_ff <= '0;
         qhold_ff <= '0;
         or_ff    <= 1'b0;
      end else if (!trimming) begin
         or_ff <= any_or;
         if (!eff_demux) begin
            ip_ff <= i_code;
            qp_ff <= q_code;
         end else if (!phase_ff) begin
            ihold_ff <= i_code;
            qhold_ff <= q_code;
         end else begin
            id_ff <= ihold_ff;
            qd_ff <= qhold_ff;
            ip_ff <= i_code;
            qp_ff <= q_code;
         end
      end
   end

   // Output clock, settings and active flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         output_data_clock_ff  <= 1'b0;
         swing_ff <= 1'b0;
         edge_ff  <= 1'b0;
         fsr_ff   <= 1'b0;
         act_ff   <= 1'b0;
         trim_ff  <= 1'b0;
      end else begin
         output_data_clock_ff  <= trimming ? 1'b0 : (eff_demux ? !phase_ff : !output_data_clock_ff);
         swing_ff <= eff_swing;
         edge_ff  <= eff_edge;
         fsr_ff   <= eff_fsr;
         act_ff   <= running;
         trim_ff  <= trimming;
      end
   end

   assign i_primary_bus       = ip_ff;
   assign i_delayed_bus       = id_ff;
   assign q_primary_bus       = qp_ff;
   assign q_delayed_bus       = qd_ff;
   assign out_of_range        = or_ff;
   assign output_data_clock   = output_data_clock_ff;
   assign output_swing_select = swing_ff;
   assign output_edge_select  = edge_ff;
   assign full_scale_select   = fsr_ff;
   assign calibration_active  = act_ff;
   assign trim_active         = trim_ff;
endmodule // dacc_top
`default_nettype wire

// File: dacc_checker.sv
// Purpose: Port assertions for the calibration control block.
// Assumes: One pclk domain, presetn async active low.
// Notes: Trim and bias counts come from the bound top.
`timescale 1ns/1ps
`default_nettype none
module dacc_checker #(
   parameter int TRIM_CYC = 8,
   parameter int BIAS_CYC = 16
) (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       extended_control_enable,
   input wire logic       power_down_request,
   input wire logic       cal_pin,
   input wire logic       output_swing_pin,
   input wire logic       demux_pin,
   input wire logic       i_under,
   input wire logic       i_over,
   input wire logic       q_under,
   input wire logic       q_over,
   input wire logic [7:0] i_primary_bus,
   input wire logic [7:0] q_primary_bus,
   input wire logic       out_of_range,
   input wire logic       output_data_clock,
   input wire logic       output_swing_select,
   input wire logic       pslverr,
   input wire logic       calibration_active,
   input wire logic       trim_active
);
   logic [15:0] act_ff, nxt_act, trm_ff, nxt_trm;
   logic        plain;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Pin mode, no demux, no run in progress
   assign plain = presetn && !extended_control_enable && !demux_pin && !calibration_active;
   assign nxt_act = calibration_active ? act_ff + 16'h1 : 16'h0;
   assign nxt_trm = trim_active ? trm_ff + 16'h1 : 16'h0;
   // Length of the active and trim levels
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_ff <= 16'h0;
         trm_ff <= 16'h0;
      end else begin
         act_ff <= nxt_act;
         trm_ff <= nxt_trm;
      end
   end
   property p_oor;
      $past(plain) && plain |-> out_of_range == $past(i_under | i_over | q_under | q_over);
   endproperty
   a_oor: assert property (p_oor) else $error("range flag wrong");
   property p_under;
      $past(plain) && plain && $past(i_under & ~i_over) |-> i_primary_bus == 8'h00;
   endproperty
   a_under: assert property (p_under) else $error("under-range word wrong");
   property p_over;
      $past(plain) && plain && $past(q_over & ~q_under) |-> q_primary_bus == 8'hff;
   endproperty
   a_over: assert property (p_over) else $error("over-range word wrong");
   property p_trim_in;
      trim_active |-> calibration_active;
   endproperty
   a_trim_in: assert property (p_trim_in) else $error("trim outside run");
   property p_clk_stop;
      trim_active && $past(trim_active) |-> !output_data_clock;
   endproperty
   a_clk_stop: assert property (p_clk_stop) else $error("clock runs in trim");
   property p_pd;
      power_down_request [*5] |-> !calibration_active;
   endproperty
   a_pd: assert property (p_pd) else $error("run in power-down");
   property p_len;
      $fell(calibration_active) && !$past(power_down_request)
         |-> act_ff == TRIM_CYC + BIAS_CYC || act_ff == BIAS_CYC;
   endproperty
   a_len: assert property (p_len) else $error("run length wrong");
   property p_trm_len;
      $fell(trim_active) && !$past(power_down_request) |-> trm_ff == TRIM_CYC;
   endproperty
   a_trm_len: assert property (p_trm_len) else $error("trim length wrong");
   property p_swing;
      !extended_control_enable && $past(plain) |-> output_swing_select == $past(output_swing_pin);
   endproperty
   a_swing: assert property (p_swing) else $error("swing select wrong");
   property p_pin_req;
      $rose(calibration_active) && !extended_control_enable |-> $past(cal_pin, 3) && $past(cal_pin);
   endproperty
   a_pin_req: assert property (p_pin_req) else $error("run without request");
   c_trim: cover property ($rose(trim_active));
   c_run: cover property ($fell(calibration_active));
   c_err: cover property (pslverr);
   c_oor: cover property (out_of_range && plain);
endmodule // dacc_checker
bind dacc_top dacc_checker #(.TRIM_CYC(TRIM_CYC), .BIAS_CYC(BIAS_CYC)) u_chk (
   .pclk, .presetn, .extended_control_enable, .power_down_request, .cal_pin,
   .output_swing_pin, .demux_pin, .i_under, .i_over, .q_under, .q_over, .i_primary_bus,
   .q_primary_bus, .out_of_range, .output_data_clock, .output_swing_select, .pslverr,
   .calibration_active, .trim_active);
`default_nettype wire

// File: dacc_host.sv
// Purpose: Host side model driving the calibrate pin.
// Assumes: Pin rests high, so reset alone requests nothing.
// Notes: One go pulse gives a low period, then a held high.
`timescale 1ns/1ps
`default_nettype none
module dacc_host #(
   parameter int LOW_CYC  = 90,
   parameter int HIGH_CYC = 90
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic go,
   output logic      cal_pin
);
   int cnt_ff;
   // Request shape; pin then stays high and still during the run
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cal_pin <= 1'b1;
         cnt_ff <= 0;
      end else if (go && cnt_ff == 0) begin
         cal_pin <= 1'b0;
         cnt_ff <= LOW_CYC + HIGH_CYC;
      end else if (cnt_ff != 0) begin
         cnt_ff <= cnt_ff - 1;
         if (cnt_ff == HIGH_CYC) cal_pin <= 1'b1;
      end
   end
endmodule // dacc_host
`default_nettype wire

// File: dacc_top_tb.sv
// Purpose: Self-checking bench for the calibration control block.
// Assumes: APB answers when pready is high; short trim and bias.
// Notes: Drivers queue expectations, monitors compare them.
`timescale 1ns/1ps
`default_nettype none
module dacc_top_tb;
   localparam int TRIM = 8;
   localparam int BIAS = 16;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, go, cal_pin;
   logic extended_control_enable, power_down_request, output_swing_pin, output_edge_pin;
   logic full_scale_pin, demux_pin, i_under, i_over, q_under, q_over, prev_bit;
   logic fs_sel, edge_sel;
   logic [7:0]  paddr, i_sample, q_sample, i_primary_bus, prev;
   logic [7:0]  i_delayed_bus, q_primary_bus, q_delayed_bus;
   logic [31:0] pwdata, prdata;
   logic [31:0] rd_q[$];
   logic [7:0]  dq[$];
   time         due_q[$];
   int          fails = 0, n_compared = 0, seed = 32'h95a97d48, n;
   dacc_top #(.TRIM_CYC(TRIM), .BIAS_CYC(BIAS)) u_dut (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .extended_control_enable, .power_down_request, .cal_pin, .output_swing_pin,
      .output_edge_pin, .full_scale_pin, .demux_pin, .i_sample, .q_sample, .i_under,
      .i_over, .q_under, .q_over, .i_primary_bus, .i_delayed_bus, .q_primary_bus,
      .q_delayed_bus, .out_of_range(), .output_data_clock(), .output_swing_select(prev_bit),
      .output_edge_select(edge_sel), .full_scale_select(fs_sel), .calibration_active(),
      .trim_active());
   dacc_host u_host (.pclk, .presetn, .go, .cal_pin);
   // Clock
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task automatic give_verdict();
      $display("compared %0d failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      cmp32({24'h0, got}, {24'h0, exp});
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] exp);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      if (!wr) rd_q.push_back(exp);
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (k == 20) begin
         fails++;
         give_verdict();
      end
      cmp32({31'h0, pslverr}, {31'h0, a > 8'h08});
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic cal_len(output int len);
      int k;
      len = 0;
      for (k = 0; k < 400 && u_dut.calibration_active !== 1'b1; k++) @(posedge pclk);
      for (k = 0; k < 3000 && u_dut.calibration_active === 1'b1; k++) begin
         @(posedge pclk);
         len++;
      end
      if (k == 3000) begin
         fails++;
         give_verdict();
      end
   endtask
   task automatic stream(input int cyc);
      logic [7:0] v;
      logic [3:0] r;
      repeat (cyc) begin
         v = 8'($random(seed));
         r = 4'($random(seed) & $random(seed));
         if (r[3]) r[2] = 1'b0;
         if (r[1]) r[0] = 1'b0;
         i_sample <= v;
         q_sample <= ~v;
         output_swing_pin <= v[0];
         {i_under, i_over, q_under, q_over} <= r;
         dq.push_back(r[3] ? 8'h00 : r[2] ? 8'hff : v);
         due_q.push_back($time + 150);
         @(posedge pclk);
      end
      {i_under, i_over, q_under, q_over} <= 4'h0;
   endtask
   task automatic reg_cal(input logic [31:0] ctl, input int exp);
      int len;
      apb(1'b1, dacc_pkg::ADDR_CTRL, ctl, 32'h0);
      repeat (90) @(posedge pclk);
      apb(1'b1, dacc_pkg::ADDR_CTRL, ctl | 32'h1, 32'h0);
      cal_len(len);
      cmp32(len, exp);
   endtask
   // Read data monitor at the answering edge
   always @(posedge pclk)
      if (psel && penable && pready && !pwrite && rd_q.size() > 0) cmp32(prdata, rd_q.pop_front());
   // Data word monitor once the word has settled
   always @(negedge pclk)
      if (due_q.size() > 0 && due_q[0] <= $time) begin
         void'(due_q.pop_front());
         cmp8(i_primary_bus, dq.pop_front());
      end
   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, go, power_down_request, output_swing_pin} = 7'h0;
      {output_edge_pin, full_scale_pin, demux_pin, i_under, i_over, q_under, q_over} = 7'h0;
      {paddr, pwdata, i_sample, q_sample} = 56'h0;
      extended_control_enable = 1'b1;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      cal_len(n);
      cmp32(n, 0);
      apb(1'b0, dacc_pkg::ADDR_CTRL, 32'h0, dacc_pkg::CTRL_RESET);
      apb(1'b0, dacc_pkg::ADDR_CONFIG, 32'h0, dacc_pkg::CONFIG_RESET);
      apb(1'b0, dacc_pkg::ADDR_STATUS, 32'h0, 32'h1);
      apb(1'b0, 8'h0c, 32'h0, 32'h0);
      $display("test reset done");
      @(posedge pclk);
      extended_control_enable <= 1'b0;
      repeat (3) @(posedge pclk);
      stream(40);
      demux_pin <= 1'b1;
      // Three edges put the hold phase on the last of them, so the first loop edge updates both buses
      repeat (3) @(posedge pclk);
      n = 0;
      prev = i_primary_bus;
      repeat (20) begin
         i_sample <= i_sample + 8'h01;
         q_sample <= q_sample - 8'h01;
         @(negedge pclk);
         if (i_primary_bus !== prev) begin
            n++;
            cmp8(i_delayed_bus, i_primary_bus - 8'h01);
            cmp8(q_delayed_bus, q_primary_bus + 8'h01);
         end
         prev = i_primary_bus;
         @(posedge pclk);
      end
      cmp32(n, 10);
      demux_pin <= 1'b0;
      $display("test data done");
      full_scale_pin <= 1'b1;
      output_edge_pin <= 1'b1;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      cal_len(n);
      cmp32(n, TRIM + BIAS);
      cmp32({30'h0, fs_sel, edge_sel}, 32'h3);
      stream(10);
      power_down_request <= 1'b1;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      cal_len(n);
      cmp32(n, 0);
      power_down_request <= 1'b0;
      $display("test pin calibration done");
      extended_control_enable <= 1'b1;
      apb(1'b1, dacc_pkg::ADDR_CONFIG, 32'h9, 32'h0);
      apb(1'b0, dacc_pkg::ADDR_CONFIG, 32'h0, 32'h9);
      cmp32({31'h0, prev_bit}, 32'h1);
      cmp32({30'h0, fs_sel, edge_sel}, 32'h0);
      reg_cal(32'h4, 0);
      reg_cal(32'h6, BIAS);
      apb(1'b0, dacc_pkg::ADDR_CTRL, 32'h0, 32'h7);
      reg_cal(32'h2, BIAS);
      apb(1'b1, 8'h0c, 32'hff, 32'h0);
      apb(1'b0, 8'h0c, 32'h0, 32'h0);
      $display("test register calibration done");
      give_verdict();
   end
endmodule // dacc_top_tb
`default_nettype wire
